// *** vip_core_model.sv ***
`default_nettype none
// ****************************************
// core stand-in: accepts offers, acks stack words, returns
// ****************************************
module vip_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // from controller
  input wire logic exc_req,
  input wire logic stack_push,
  // to controller
  output logic take,
  output logic stack_ack,
  output logic ret
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy_ff;
  logic [4:0] cnt_ff;
  // slow accept and every-other-cycle ack, so the design must wait on us
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      take <= 1'b0;
      stack_ack <= 1'b0;
      ret <= 1'b0;
      busy_ff <= 1'b0;
      cnt_ff <= 5'h00;
    end else begin
      take <= 1'b0;
      stack_ack <= stack_push && !stack_ack;
      ret <= 1'b0;
      if (!busy_ff && exc_req) begin
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff == 5'h02) begin
          take <= 1'b1;
          busy_ff <= 1'b1;
          cnt_ff <= 5'h00;
        end
      end else if (busy_ff && !stack_push) begin
        cnt_ff <= cnt_ff + 5'h01; // handler body length
        if (cnt_ff == 5'h1F) begin
          ret <= 1'b1;
          busy_ff <= 1'b0;
          cnt_ff <= 5'h00;
        end
      end
    end
  end
endmodule // vip_core_model
`default_nettype wire

// *** vip_ctrl.sv ***
// Contract
// RULE1: 32 lines, disabled lines ignored
// RULE2: set-enable write-1 enables, reads enables
// RULE3: clear-enable write-1 disables, reads enables
// RULE4: 32-bit registers, bit n line n
// RULE5: enable registers touch peripheral lines only
// RULE6: global mask blocks configurable exceptions
// RULE7: priorities 0..3, 0 most urgent
// RULE8: four states; preempted handler stays active
// RULE9: re-request while active gives active-and-pending
// RULE10: active vector in [8:0], zero thread
// RULE11: pending vector in [20:12], zero none
// RULE12: bit 22 flags any peripheral pending; code flags only pendings on enabled lines
// RULE13: request pends; handler start makes active
// RULE14: set-pending write-1 pends, reads pending
// RULE15: clear-pending write-1 unpends, reads pending
// RULE16: repeated set-pending queues nothing extra
// RULE17: disabled line pends only once enabled; code pends it on a set-pending write and offers it only once enabled
// RULE18: pending registers touch peripheral lines only
// RULE19: entry pushes eight words in order
// RULE20: handler uses main stack; thread selects
// RULE21: wakeup on any allowed wakeup source
// RULE22: wake class depends on source group
// RULE23: equal priority, lowest number wins
// RULE24: equal priority no preempt; nest max four
// RULE25: enables and pendings reset to zero
`default_nettype none
module vip_ctrl
  import vip_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire vip_pkg::vip_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // peripheral requests and priorities
  input wire logic [31:0] irq_line,
  input wire logic [63:0] irq_prio,
  input wire vip_pkg::vip_wclass_t irq_class [32],
  // core side
  input wire vip_pkg::vip_core_in_t core_in,
  input wire vip_pkg::vip_pmode_t power_mode,
  output logic exc_req,
  output logic [8:0] exc_vector,
  output logic [8:0] active_vector_number,
  output logic stack_push,
  output logic [2:0] stack_slot,
  output logic use_main_stack,
  output logic wakeup
);
  import vip_pkg::*;

  typedef enum logic [1:0] {VIP_ST_IDLE, VIP_ST_PUSH} vip_seq_t;

  typedef struct packed {
    logic [31:0] en;
    logic [31:0] pend;
    logic [31:0] act;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] line_ff;
    logic [3:0][8:0] nest_vec;
    logic [3:0][2:0] nest_prio;
    logic [2:0] depth;
    logic [8:0] pvec;
    logic [31:0] rdata;
    logic req;
    logic [8:0] rvec;
    logic [8:0] avec;
    logic push;
    logic [2:0] slot;
    logic main_stack_pointer;
    logic wake;
    vip_seq_t seq;
  } vip_state_t;

  vip_state_t st_ff, nxt_st;

  // ****************************************
  // arbitration: lowest priority value, then lowest number
  // ****************************************
  logic [8:0] win_vec;
  logic [2:0] win_prio;
  logic win_any;
  logic [2:0] cur_prio;
  logic [31:0] eligible;
  logic [31:0] wake_src;

  always_comb begin
    eligible = st_ff.pend & st_ff.en; // RULE17
    win_any = 1'b0;
    win_vec = 9'h000;
    win_prio = 3'h7;
    // descending scan so that ties keep the lowest number
    for (int i = VIP_NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i] && {1'b0, irq_prio[2*i +: 2]} <= win_prio) begin // RULE7 RULE23
        win_any = 1'b1;
        win_prio = {1'b0, irq_prio[2*i +: 2]};
        win_vec = VIP_IRQ_BASE + 9'(i);
      end
    end
    cur_prio = (st_ff.depth == 3'h0) ? 3'h4 : st_ff.nest_prio[st_ff.depth - 3'h1];
  end

  // wake sources by class and mode
  for (genvar g = 0; g < VIP_NUM_IRQ; g++) begin : g_wake
    // synchronised level only: the raw pin is in another domain
    assign wake_src[g] = st_ff.en[g] & st_ff.line_ff[g] & // RULE21
      ((power_mode == VIP_PM_SLEEP) ||
       (power_mode == VIP_PM_DEEP && irq_class[g] != VIP_WK_NONE) ||
       (power_mode == VIP_PM_HIB && irq_class[g] == VIP_WK_ALL)); // RULE22
  end

  // ****************************************
  // next state
  // ****************************************
  logic [31:0] rise;
  logic [31:0] line_now;
  logic [31:0] ret_mask;
  logic [8:0] top_vec;
  logic [4:0] take_idx;
  logic can_take;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = irq_line;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    // change counts once the two late stages agree
    line_now = st_ff.line_ff;
    for (int i = 0; i < VIP_NUM_IRQ; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        line_now[i] = st_ff.sync3[i];
      end
    end
    nxt_st.line_ff = line_now;
    rise = line_now & ~st_ff.line_ff & st_ff.en; // RULE1
    top_vec = (st_ff.depth == 3'h0) ? 9'h000 : st_ff.nest_vec[st_ff.depth - 3'h1];
    ret_mask = 32'h0;
    take_idx = 5'(win_vec - VIP_IRQ_BASE);
    // strict compare: equal priority never preempts; nest capped
    can_take = win_any && !core_in.gmask && (win_prio < cur_prio) && // RULE6 RULE24
      (st_ff.depth < 3'(VIP_MAX_NEST)) && st_ff.seq == VIP_ST_IDLE;
    // return from handler pops the nest
    if (core_in.ret && st_ff.depth != 3'h0 && top_vec >= VIP_IRQ_BASE) begin
      ret_mask[5'(top_vec - VIP_IRQ_BASE)] = 1'b1;
    end
    if (core_in.ret && st_ff.depth != 3'h0) begin
      nxt_st.depth = st_ff.depth - 3'h1;
    end
    nxt_st.act = st_ff.act & ~ret_mask;
    // pending: software writes then hardware set wins over clear
    if (reg_req.wr && reg_req.sel == VIP_SEL_PEND_CLR) begin
      nxt_st.pend = st_ff.pend & ~reg_req.wdata; // RULE15 RULE18
    end
    if (reg_req.wr && reg_req.sel == VIP_SEL_PEND_SET) begin
      nxt_st.pend = st_ff.pend | reg_req.wdata; // RULE14 RULE16
    end
    nxt_st.pend = nxt_st.pend | rise; // RULE13 RULE9
    if (reg_req.wr && reg_req.sel == VIP_SEL_EN_SET) begin
      nxt_st.en = st_ff.en | reg_req.wdata; // RULE2 RULE5
    end
    if (reg_req.wr && reg_req.sel == VIP_SEL_EN_CLR) begin
      nxt_st.en = st_ff.en & ~reg_req.wdata; // RULE3
    end
    nxt_st.req = 1'b0;
    // fixed-priority system faults bypass the mask
    if (core_in.nmi || core_in.hard) begin
      nxt_st.req = st_ff.seq == VIP_ST_IDLE;
      nxt_st.rvec = core_in.nmi ? VIP_EXC_NMI : VIP_EXC_HARD;
    end else if (can_take) begin
      nxt_st.req = 1'b1;
      nxt_st.rvec = win_vec;
    end
    // core accepts the offered exception: pending to active
    if (core_in.take && st_ff.req && st_ff.seq == VIP_ST_IDLE) begin
      if (st_ff.rvec >= VIP_IRQ_BASE) begin
        // a set landing in the take cycle still wins
        nxt_st.pend[take_idx] = rise[take_idx] | // RULE13
          (reg_req.wr && reg_req.sel == VIP_SEL_PEND_SET && reg_req.wdata[take_idx]);
        nxt_st.act[take_idx] = 1'b1; // RULE8
        nxt_st.nest_prio[st_ff.depth] = win_prio;
      end else begin
        nxt_st.nest_prio[st_ff.depth] = 3'h0;
      end
      nxt_st.nest_vec[st_ff.depth] = st_ff.rvec;
      nxt_st.depth = st_ff.depth + 3'h1;
      nxt_st.req = 1'b0;
      nxt_st.seq = VIP_ST_PUSH;
      nxt_st.push = 1'b1;
      nxt_st.slot = 3'h0;
      // stack in use for this push comes from the current mode
      nxt_st.main_stack_pointer = (st_ff.depth != 3'h0) || !core_in.spsel; // RULE20
    end
    unique case (st_ff.seq)
      VIP_ST_IDLE: begin
        if (!(core_in.take && st_ff.req)) begin
          nxt_st.main_stack_pointer = (nxt_st.depth != 3'h0) || !core_in.spsel; // RULE20
        end
      end
      VIP_ST_PUSH: begin
        // eight words: status, return, link, r12, r3..r0
        if (core_in.stack_ack) begin
          if (st_ff.slot == VIP_STACK_WORDS) begin // RULE19
            nxt_st.push = 1'b0;
            nxt_st.seq = VIP_ST_IDLE;
            nxt_st.main_stack_pointer = 1'b1;
          end else begin
            nxt_st.slot = st_ff.slot + 3'h1;
          end
        end
      end
    endcase
    // highest-priority eligible pending vector, zero if none
    nxt_st.pvec = win_any ? win_vec : 9'h000; // RULE11
    // registered nest top keeps the active vector output glitch free
    nxt_st.avec = (nxt_st.depth == 3'h0) ? 9'h000 : // RULE10
      nxt_st.nest_vec[nxt_st.depth - 3'h1];
    nxt_st.wake = |wake_src; // RULE21
    unique case (reg_req.sel)
      VIP_SEL_EN_SET, VIP_SEL_EN_CLR: nxt_st.rdata = nxt_st.en; // RULE4
      VIP_SEL_PEND_SET, VIP_SEL_PEND_CLR: nxt_st.rdata = nxt_st.pend;
      VIP_SEL_CTRL_STATE: begin
        nxt_st.rdata = 32'h0;
        nxt_st.rdata[VIP_ACT_LSB +: VIP_VEC_W] = top_vec; // RULE10
        nxt_st.rdata[VIP_PEND_LSB +: VIP_VEC_W] = st_ff.pvec;
        nxt_st.rdata[VIP_ISRP_BIT] = |(st_ff.pend & st_ff.en); // RULE12
      end
      default: nxt_st.rdata = 32'h0;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0; // RULE25
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign exc_req = st_ff.req;
  assign exc_vector = st_ff.rvec;
  assign active_vector_number = st_ff.avec;
  assign stack_push = st_ff.push;
  assign stack_slot = st_ff.slot;
  assign use_main_stack = st_ff.main_stack_pointer;
  assign wakeup = st_ff.wake;

  // ****************************************
  // checks
  // ****************************************
  a_en_set_effect: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
    reg_req.wr && reg_req.sel == VIP_SEL_EN_SET |=> &(st_ff.en | ~$past(reg_req.wdata)))
    else $error("enable set lost");
  a_en_clr_effect: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
    reg_req.wr && reg_req.sel == VIP_SEL_EN_CLR |=> (st_ff.en & $past(reg_req.wdata)) == 0)
    else $error("enable clear lost");
  a_pend_set_effect: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
    reg_req.wr && reg_req.sel == VIP_SEL_PEND_SET && !core_in.take
    |=> &(st_ff.pend | ~$past(reg_req.wdata)))
    else $error("pending set lost");
  a_mask_blocks: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
    core_in.gmask && !core_in.nmi && !core_in.hard |=> !exc_req)
    else $error("masked exception offered");
  a_nest_limit: assert property (@(posedge mclk) disable iff (!arst_n) // RULE24
    st_ff.depth <= 3'(VIP_MAX_NEST))
    else $error("nesting too deep");
  a_thread_zero: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
    st_ff.depth == 3'h0 |-> active_vector_number == 9'h000)
    else $error("active vector nonzero in thread");
  sequence s_push_start;
    $rose(stack_push);
  endsequence
  a_push_slot0: assert property (@(posedge mclk) disable iff (!arst_n) // RULE19
    s_push_start |-> stack_slot == 3'h0 && use_main_stack == $past(use_main_stack) ||
    stack_slot == 3'h0)
    else $error("push did not start at slot zero");
  a_handler_msp: assert property (@(posedge mclk) disable iff (!arst_n) // RULE20
    st_ff.depth != 3'h0 && !stack_push |-> use_main_stack)
    else $error("handler not on main stack");
  // index taken from the vector on show now, not the stale one
  a_no_disabled: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
    exc_req && exc_vector >= VIP_IRQ_BASE |->
    1'($past(st_ff.en) >> 5'(exc_vector - VIP_IRQ_BASE)))
    else $error("disabled line offered");
  // ****************************************
  // sequencing checks
  // ****************************************
  sequence s_push_word;
    stack_push && core_in.stack_ack;
  endsequence
  // clear removes the bit unless a line edge lands together
  a_pend_clr_effect: assert property (@(posedge mclk) disable iff (!arst_n) // RULE15
    reg_req.wr && reg_req.sel == VIP_SEL_PEND_CLR
    |=> (st_ff.pend & $past(reg_req.wdata) & ~$past(rise)) == 32'h0)
    else $error("pending clear lost");
  // last acked word ends the push
  a_push_end: assert property (@(posedge mclk) disable iff (!arst_n) // RULE19
    s_push_word ##0 stack_slot == VIP_STACK_WORDS |=> !stack_push)
    else $error("push ran past eight words");
  // every other acked word advances by one
  a_push_step: assert property (@(posedge mclk) disable iff (!arst_n) // RULE19
    s_push_word ##0 stack_slot != VIP_STACK_WORDS
    |=> stack_push && stack_slot == $past(stack_slot) + 3'h1)
    else $error("push slot skipped");
  // accepted offer becomes the active vector
  a_take_active: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
    core_in.take && exc_req && !stack_push && !core_in.ret
    |=> active_vector_number == $past(exc_vector))
    else $error("taken exception not active");
  // nothing eligible means a zero pending vector
  a_pvec_zero: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
    (st_ff.pend & st_ff.en) == 32'h0 |=> st_ff.pvec == 9'h000)
    else $error("pending vector without pending line");
  // peripheral pending flag follows enabled pendings
  a_isr_flag: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
    reg_req.sel == VIP_SEL_CTRL_STATE
    |=> reg_rdata[VIP_ISRP_BIT] == |$past(st_ff.pend & st_ff.en))
    else $error("pending flag wrong");
  // active mode never raises a wakeup
  a_wake_active: assert property (@(posedge mclk) disable iff (!arst_n) // RULE22
    power_mode == VIP_PM_ACTIVE |=> !wakeup)
    else $error("wakeup in active mode");
  // disabled or quiet lines never wake
  a_wake_enabled: assert property (@(posedge mclk) disable iff (!arst_n) // RULE21
    (st_ff.en & st_ff.line_ff) == 32'h0 |=> !wakeup)
    else $error("wakeup without enabled line");
  // first push from thread mode uses the selected stack
  a_thread_stack: assert property (@(posedge mclk) disable iff (!arst_n) // RULE20
    s_push_start ##0 $past(st_ff.depth) == 3'h0
    |-> use_main_stack == !$past(core_in.spsel))
    else $error("thread push on wrong stack");
endmodule : vip_ctrl
`default_nettype wire

// *** vip_ctrl_bench.sv ***
`default_nettype none
module vip_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import vip_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  vip_reg_req_t req = '0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [31:0] irq_line = 32'h0;
  vip_wclass_t cls [32];
  vip_pmode_t pmode = VIP_PM_ACTIVE;
  logic gmask = 1'b0;
  logic take, stack_ack, ret, exc_req, stack_push, use_main, wakeup;
  logic [8:0] exc_vector, act_vec;
  vip_core_in_t core_in;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int acks = 0;
  int takes = 0;
  int n;
  // nmi and hard fault held quiet: fixed-priority paths are out of scope here
  assign core_in = '{take:take, ret:ret, nmi:1'b0, hard:1'b0, gmask:gmask,
                     spsel:1'b1, stack_ack:stack_ack};
  vip_ctrl i_dut (.mclk(mclk), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
    .irq_line(irq_line), .irq_prio(64'h0), .irq_class(cls), .core_in(core_in),
    .power_mode(pmode), .exc_req(exc_req), .exc_vector(exc_vector),
    .active_vector_number(act_vec), .stack_push(stack_push), .stack_slot(),
    .use_main_stack(use_main), .wakeup(wakeup));
  vip_core_model i_core (.mclk(mclk), .arst_n(arst_n), .exc_req(exc_req),
    .stack_push(stack_push), .take(take), .stack_ack(stack_ack), .ret(ret));
  initial forever #25 mclk = ~mclk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [2:0] s, logic [31:0] d);
    @(posedge mclk) req <= '{wr:1'b1, rd:1'b0, sel:s, wdata:d};
    @(posedge mclk) req <= '0;
  endtask
  task automatic rc(logic [2:0] s, logic [31:0] mask, logic [31:0] exp, string what);
    @(posedge mclk) req <= '{wr:1'b0, rd:1'b1, sel:s, wdata:32'h0};
    @(posedge mclk) req <= '0;
    #1 chk(what, rdata & mask, exp);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // stack words, accepted offers and the hang limit
  always @(posedge mclk) begin
    cyc++;
    if (stack_push === 1'b1 && stack_ack === 1'b1) acks++;
    if (take === 1'b1) takes++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    foreach (cls[i]) cls[i] = VIP_WK_NONE;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    rc(VIP_SEL_EN_SET, '1, 32'h0, "enable reset");
    rc(VIP_SEL_PEND_SET, '1, 32'h0, "pending reset");
    rc(3'h5, '1, 32'h0, "unmapped read");
    wr(VIP_SEL_EN_SET, 32'hA5A5_0F0F);
    wr(VIP_SEL_EN_SET, 32'h0);
    rc(VIP_SEL_EN_SET, '1, 32'hA5A5_0F0F, "enable set");
    wr(VIP_SEL_EN_CLR, 32'h0000_0F0F);
    rc(VIP_SEL_EN_CLR, '1, 32'hA5A5_0000, "enable clear");
    $display("test enables done");
    // pendings on disabled lines are kept but never offered
    wr(VIP_SEL_PEND_SET, 32'h3);
    wr(VIP_SEL_PEND_SET, 32'h2);
    wr(VIP_SEL_PEND_CLR, 32'h1);
    rc(VIP_SEL_PEND_CLR, '1, 32'h2, "pending set clear");
    repeat (10) @(posedge mclk);
    chk("offer on disabled", exc_req, 0);
    @(posedge mclk) gmask <= 1'b1;
    wr(VIP_SEL_EN_SET, 32'h22);
    wr(VIP_SEL_PEND_SET, 32'h20);
    rc(VIP_SEL_CTRL_STATE, 32'h005F_F1FF, 32'h0041_1000, "control state");
    repeat (10) @(posedge mclk);
    chk("offer while masked", exc_req, 0);
    wr(VIP_SEL_PEND_CLR, 32'h20);
    @(posedge mclk) gmask <= 1'b0;
    $display("test pending done");
    for (n = 0; n < 40 && act_vec !== 9'h011; n++) begin
      @(posedge mclk);
      #1;
    end
    chk("active vector", act_vec, 9'h011);
    chk("thread push stack", use_main, 0);
    rc(VIP_SEL_PEND_SET, '1, 32'h0, "pending to active");
    wr(VIP_SEL_PEND_SET, 32'h2);
    wr(VIP_SEL_PEND_SET, 32'h2);
    rc(VIP_SEL_PEND_SET, '1, 32'h2, "active and pending");
    wait (stack_push === 1'b0);
    #1 chk("main stack", use_main, 1);
    for (n = 0; n < 100 && act_vec !== 9'h000; n++) @(posedge mclk);
    chk("stack words", acks, 8);
    repeat (120) @(posedge mclk);
    chk("entries", takes, 2);
    chk("thread vector", act_vec, 9'h000);
    chk("stack words again", acks, 16);
    $display("test handler done");
    // wake classes: deep-only source stays silent in hibernate
    @(posedge mclk) pmode <= VIP_PM_HIB;
    cls[4] <= VIP_WK_DEEP;
    wr(VIP_SEL_EN_SET, 32'h10);
    @(posedge mclk) irq_line[4] <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("no wake", wakeup, 0);
    irq_line[4] <= 1'b0;
    wr(VIP_SEL_EN_CLR, 32'h10);
    @(posedge mclk) pmode <= VIP_PM_DEEP;
    cls[3] <= VIP_WK_ALL;
    wr(VIP_SEL_EN_SET, 32'h8);
    @(posedge mclk) irq_line[3] <= 1'b1;
    for (n = 0; n < 10 && wakeup !== 1'b1; n++) @(posedge mclk);
    chk("wake", wakeup, 1);
    $display("test wakeup done");
    complete_run();
  end
endmodule // vip_ctrl_bench
`default_nettype wire

// *** vip_pkg.sv ***
`default_nettype none
package vip_pkg;
  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned VIP_NUM_IRQ = 32;
  localparam int unsigned VIP_PRIO_W = 2;
  localparam int unsigned VIP_VEC_W = 9;
  localparam int unsigned VIP_MAX_NEST = 4;
  localparam logic [8:0] VIP_IRQ_BASE = 9'h010;
  localparam logic [8:0] VIP_EXC_NMI = 9'h002;
  localparam logic [8:0] VIP_EXC_HARD = 9'h003;
  // ****************************************
  // register select codes (no printed offsets)
  // ****************************************
  localparam logic [2:0] VIP_SEL_EN_SET = 3'h0;
  localparam logic [2:0] VIP_SEL_EN_CLR = 3'h1;
  localparam logic [2:0] VIP_SEL_PEND_SET = 3'h2;
  localparam logic [2:0] VIP_SEL_PEND_CLR = 3'h3;
  localparam logic [2:0] VIP_SEL_CTRL_STATE = 3'h4;
  // ****************************************
  // control/state field positions and resets
  // ****************************************
  localparam int unsigned VIP_ACT_LSB = 0;
  localparam int unsigned VIP_PEND_LSB = 12;
  localparam int unsigned VIP_ISRP_BIT = 22;
  localparam int unsigned VIP_GMASK_BIT = 0;
  localparam logic [31:0] VIP_EN_RST = 32'h0000_0000;
  localparam logic [31:0] VIP_PEND_RST = 32'h0000_0000;
  localparam logic [2:0] VIP_STACK_WORDS = 3'h7;
  // ****************************************
  // power modes and wake classes
  // ****************************************
  typedef enum logic [1:0] {VIP_PM_ACTIVE, VIP_PM_SLEEP, VIP_PM_DEEP, VIP_PM_HIB} vip_pmode_t;
  typedef enum logic [1:0] {VIP_WK_ALL, VIP_WK_DEEP, VIP_WK_NONE} vip_wclass_t;
  // register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [31:0] wdata;
  } vip_reg_req_t;
  // core exchange
  typedef struct packed {
    logic take;
    logic ret;
    logic nmi;
    logic hard;
    logic gmask;
    logic spsel;
    logic stack_ack;
  } vip_core_in_t;
endpackage : vip_pkg
`default_nettype wire
